// [src/scss_top.sv]
// system clock source switch with its ahb-lite control register
`timescale 1ns/100ps
`include "scss_map.svh"
module scss_top
  import scss_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] haddr,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [3:0] osc_type_config,
  input wire logic switch_enable_config,
  input wire logic secondary_osc_enable,
  input wire logic pll_lock,
  input wire logic [2:0] clk_gate_ack,
  output logic pll_enable,
  output logic [2:0] clk_gate_en,
  output logic [1:0] sys_clk_src,
  output logic switch_busy
);

  //////////////////////////////////////////////////////////////////////////
  // bus front end

  scss_ahb_req_t req;
  logic rd_take;
  logic rd_hit;
  logic wr_commit;
  logic wr_hit;
  logic ctrl_wr;

  assign req.sel = hsel;
  assign req.trans = htrans;
  assign req.write = hwrite;
  assign req.size = hsize;
  assign req.addr = haddr[11:0];

  scss_ahb_port u_port (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .req(req),
    .hready(hready),
    .rd_take(rd_take),
    .rd_hit(rd_hit),
    .wr_commit(wr_commit),
    .wr_hit(wr_hit)
  );

  assign ctrl_wr = wr_commit & wr_hit;

  //////////////////////////////////////////////////////////////////////////
  // oscillator mode decode

  logic mode_ext_cfg;
  logic mode_xtal_cfg;
  logic mode_ext_soft;
  logic mode_xtal_soft;
  logic cfg_pll;
  logic soft_pll;

  assign mode_ext_cfg = (osc_type_config == `SCSS_MODE_EXT_CFG_PLL);
  assign mode_xtal_cfg = (osc_type_config == `SCSS_MODE_XTAL_CFG_PLL);
  assign mode_ext_soft = (osc_type_config == `SCSS_MODE_EXT_SOFT_PLL);
  assign mode_xtal_soft = (osc_type_config == `SCSS_MODE_XTAL_SOFT_PLL);
  assign cfg_pll = mode_ext_cfg | mode_xtal_cfg;
  assign soft_pll = mode_ext_soft | mode_xtal_soft;

  //////////////////////////////////////////////////////////////////////////
  // oscillator control register

  logic sec_sel_q;
  logic sec_sel_d;
  logic pll_sel_q;
  logic pll_sel_d;
  logic pll_en_q;
  logic pll_en_d;
  logic wr_sec_sel;
  logic wr_pll_sel;
  logic wr_pll_en;
  logic sec_allow;
  logic pll_allow;
  logic lock_rd;
  scss_osc_ctrl_t ctrl_d;

  assign wr_sec_sel = hwdata[`SCSS_BIT_SEC_SEL];
  assign wr_pll_sel = hwdata[`SCSS_BIT_PLL_SEL];
  assign wr_pll_en = hwdata[`SCSS_BIT_PLL_EN];

  // pll enable: forced on, writable, or forced off by the mode
  assign pll_en_d = cfg_pll ? 1'b1 :
                    (soft_pll ? (ctrl_wr ? wr_pll_en : pll_en_q) :
                     1'b0);

  // pll select only survives in software pll modes with a locked pll
  assign pll_allow = soft_pll & pll_en_d & pll_lock;
  assign pll_sel_d = pll_allow &
                     (ctrl_wr ? wr_pll_sel : pll_sel_q);

  // secondary select needs switching allowed and the oscillator on
  assign sec_allow = ~switch_enable_config &
                     secondary_osc_enable;
  assign sec_sel_d = sec_allow &
                     (ctrl_wr ? wr_sec_sel : sec_sel_q);

  // stable flag shows only while the pll is offered
  assign lock_rd = pll_lock & pll_en_d;

  assign ctrl_d.lock = lock_rd;
  assign ctrl_d.pll_en = pll_en_d;
  assign ctrl_d.pll_sel = pll_sel_d;
  assign ctrl_d.sec_sel = sec_sel_d;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sec_sel_q <= 1'b0;
    end else if (ce) begin
      sec_sel_q <= sec_sel_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pll_sel_q <= 1'b0;
      pll_en_q <= 1'b0;
    end else if (ce) begin
      pll_sel_q <= pll_sel_d;
      pll_en_q <= pll_en_d;
    end
  end

  assign pll_enable = pll_en_q;

  //////////////////////////////////////////////////////////////////////////
  // read data and response

  logic [31:0] rd_word;
  logic [31:0] hrdata_q;
  logic hreadyout_q;
  logic hresp_q;

  // built from next values so a read right after a write sees it
  assign rd_word = rd_hit ? {28'h0000000, ctrl_d} : 32'h00000000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h00000000;
    end else if (ce && rd_take) begin
      hrdata_q <= rd_word;
    end
  end

  // zero wait, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end else if (ce) begin
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;

  //////////////////////////////////////////////////////////////////////////
  // source choice and gate sequencing

  scss_src_t target;
  scss_src_t cur_src;

  // secondary first, then pll, else primary
  assign target = sec_sel_q ? src_sec :
                  (pll_sel_q ? src_pll : src_pri);

  scss_switch u_switch (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .target(target),
    .gate_ack(clk_gate_ack),
    .gate_q(clk_gate_en),
    .cur_q(cur_src),
    .busy(switch_busy)
  );

  assign sys_clk_src = cur_src;

  //////////////////////////////////////////////////////////////////////////
  // checks

  chk_sec_forced: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (ce && !secondary_osc_enable) |=> !sec_sel_q)
    else $error("secondary select set without secondary oscillator");

  chk_sec_switch_cfg: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (ce && switch_enable_config) |=> !sec_sel_q)
    else $error("secondary select set while switching disabled");

  chk_pll_sel_forced: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (ce && !(pll_en_d && pll_lock)) |=> !pll_sel_q)
    else $error("pll select kept without enabled locked pll");

  chk_cfg_pll_mode: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (ce && cfg_pll) |=> (pll_en_q && !pll_sel_q))
    else $error("configuration pll mode left pll select or enable wrong");

  chk_other_modes: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (ce && !cfg_pll && !soft_pll) |=> !pll_en_q)
    else $error("pll enabled outside pll modes");

  chk_soft_write: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (ce && soft_pll && ctrl_wr) |=> pll_en_q == $past(wr_pll_en))
    else $error("pll enable write not taken in software pll mode");

  chk_upper_zero: assert property (
    @(posedge hclk) disable iff (!hresetn)
    hrdata_q[31:4] == 28'h0000000)
    else $error("unimplemented bits read nonzero");

  chk_lock_read: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (ce && rd_take && rd_hit)
    |=> hrdata_q[`SCSS_BIT_LOCK] == $past(lock_rd))
    else $error("stable flag read differs from pll state");

  chk_sec_priority: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (sec_sel_q && pll_sel_q) |-> target == src_sec)
    else $error("pll chosen over secondary");

  chk_pri_gate: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (!switch_busy && cur_src == src_pri)
    |-> clk_gate_en == `SCSS_GATE_PRI)
    else $error("primary source settled without its gate alone open");

  chk_sec_gate: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (!switch_busy && cur_src == src_sec)
    |-> clk_gate_en == `SCSS_GATE_SEC)
    else $error("secondary source settled without its gate alone open");

  chk_primary_return: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (ce && !sec_sel_q && !pll_sel_q && !switch_busy &&
     cur_src != src_pri) |=> clk_gate_en == `SCSS_GATE_NONE)
    else $error("both selects clear but no move back to primary");

  chk_sec_write: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (ce && ctrl_wr && sec_allow)
    |=> sec_sel_q == $past(wr_sec_sel))
    else $error("allowed secondary select write not taken");

  chk_pll_write: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (ce && ctrl_wr && pll_allow)
    |=> pll_sel_q == $past(wr_pll_sel))
    else $error("allowed pll select write not taken");

  chk_pll_sel_hold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (ce && !ctrl_wr && pll_allow)
    |=> pll_sel_q == $past(pll_sel_q))
    else $error("pll select moved without a write");

  chk_unmapped_read: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (ce && rd_take && !rd_hit)
    |=> hrdata_q == 32'h00000000)
    else $error("read outside the register returned nonzero");

  chk_unlocked_read: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (ce && rd_take && rd_hit && !pll_lock)
    |=> !hrdata_q[`SCSS_BIT_LOCK])
    else $error("stable flag read set while pll unlocked");

  chk_switch_start: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (ce && !switch_busy && target != cur_src)
    |=> (clk_gate_en == `SCSS_GATE_NONE && switch_busy))
    else $error("new source chosen but old gate not closed first");

  chk_gate_hold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (ce && !switch_busy && target == cur_src)
    |=> $stable(clk_gate_en))
    else $error("gates moved while source choice unchanged");

endmodule

// [inc/scss_map.svh]
// register map, field positions, reset values and encodings of the switch
//
// How it works
// - With both select bits clear the system clock runs from the primary oscillator of the configured type.
// - With the low select bit (bit 0) set the system clock comes from the secondary timer oscillator.
// - Every reset clears the low select bit so the device restarts on the primary path.
// - In software PLL modes the high select bit (bit 1) picks the PLL output when one, the primary when zero.
// - The high select bit acts only while PLL enable and PLL stable are both one, otherwise it is forced to zero.
// - In configuration PLL modes the high select bit is held at zero whatever is written.
// - Without the secondary oscillator enabled, writes to the low select bit are ignored and it stays zero.
// - The low select bit is settable only with switch-enable config at zero and secondary enable at one.
// - The PLL stable flag (bit 3) reads one when the PLL output may serve as system clock, else zero.
// - The PLL enable bit (bit 2) offers the PLL as a clock candidate when one and stops the PLL when zero.
// - PLL enable is forced on in configuration PLL modes, writable in software PLL modes, off otherwise.
// - With both select bits set the secondary oscillator wins over the PLL.
// - Bits 7 to 4 of the oscillator control register are unimplemented and read zero.
`ifndef SCSS_MAP_SVH
`define SCSS_MAP_SVH

`define SCSS_OSC_CTRL_OFF 12'h000
`define SCSS_OSC_CTRL_RST 4'h0

`define SCSS_BIT_SEC_SEL 0
`define SCSS_BIT_PLL_SEL 1
`define SCSS_BIT_PLL_EN 2
`define SCSS_BIT_LOCK 3

`define SCSS_MODE_EXT_CFG_PLL 4'h4
`define SCSS_MODE_XTAL_CFG_PLL 4'h5
`define SCSS_MODE_EXT_SOFT_PLL 4'h6
`define SCSS_MODE_XTAL_SOFT_PLL 4'h7

`define SCSS_HSIZE_WORD 3'h2

`define SCSS_GATE_NONE 3'h0
`define SCSS_GATE_PRI 3'h1
`define SCSS_GATE_PLL 3'h2
`define SCSS_GATE_SEC 3'h4

`endif

// [inc/scss_pkg.sv]
// types shared by the clock source switch
package scss_pkg;

  typedef enum logic [1:0] {
    src_pri = 2'h0,
    src_pll = 2'h1,
    src_sec = 2'h2
  } scss_src_t;

  // gray along run -> drop -> take
  typedef enum logic [1:0] {
    st_run = 2'h0,
    st_drop = 2'h1,
    st_take = 2'h3
  } scss_state_t;

  typedef struct packed {
    logic sel;
    logic [1:0] trans;
    logic write;
    logic [2:0] size;
    logic [11:0] addr;
  } scss_ahb_req_t;

  typedef struct packed {
    logic lock;
    logic pll_en;
    logic pll_sel;
    logic sec_sel;
  } scss_osc_ctrl_t;

endpackage

// [src/scss_ahb_port.sv]
// ahb-lite address phase capture and decode for the switch registers
`timescale 1ns/100ps
`include "scss_map.svh"
module scss_ahb_port
  import scss_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire scss_ahb_req_t req,
  input wire logic hready,
  output logic rd_take,
  output logic rd_hit,
  output logic wr_commit,
  output logic wr_hit
);

  logic take;
  logic hit;
  logic wr_pend_q;
  logic wr_hit_q;

  // only whole aligned words at the one mapped offset hit
  assign take = req.sel & req.trans[1] & hready;
  assign hit = (req.addr == `SCSS_OSC_CTRL_OFF) &
               (req.size == `SCSS_HSIZE_WORD);
  assign rd_take = take & ~req.write;
  assign rd_hit = hit;
  assign wr_commit = wr_pend_q & ce;
  assign wr_hit = wr_hit_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_hit_q <= 1'b0;
    end else if (ce) begin
      wr_pend_q <= take & req.write;
      wr_hit_q <= hit;
    end
  end

endmodule

// [src/scss_switch.sv]
// break-before-make sequencer for the clock source gates
`timescale 1ns/100ps
`include "scss_map.svh"
module scss_switch
  import scss_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire scss_src_t target,
  input wire logic [2:0] gate_ack,
  output logic [2:0] gate_q,
  output scss_src_t cur_q,
  output logic busy
);

  scss_state_t state_q;
  scss_state_t state_d;
  scss_src_t cur_d;
  scss_src_t nxt_q;
  scss_src_t nxt_d;
  logic [2:0] gate_d;
  logic [2:0] cur_mask;
  logic [2:0] nxt_mask;
  logic cur_on;

  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_mask
      assign cur_mask[i] = (2'(cur_q) == 2'(i));
      assign nxt_mask[i] = (2'(nxt_q) == 2'(i));
    end
  endgenerate

  assign cur_on = |(gate_ack & cur_mask);
  // state bit 0 is high in drop and take only
  assign busy = state_q[0];

  always_comb begin
    state_d = state_q;
    cur_d = cur_q;
    nxt_d = nxt_q;
    gate_d = gate_q;
    case (state_q)
      st_run: begin
        if (target != cur_q) begin
          nxt_d = target;
          gate_d = `SCSS_GATE_NONE;
          state_d = st_drop;
        end
      end
      st_drop: begin
        // old clock must be seen stopped before the new gate opens
        if (!cur_on) begin
          cur_d = nxt_q;
          gate_d = nxt_mask;
          state_d = st_take;
        end
      end
      st_take: begin
        if (target != cur_q) begin
          nxt_d = target;
          gate_d = `SCSS_GATE_NONE;
          state_d = st_drop;
        end else if (cur_on) begin
          state_d = st_run;
        end
      end
      default: begin
        gate_d = cur_mask;
        state_d = st_run;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= st_run;
      cur_q <= src_pri;
      nxt_q <= src_pri;
      gate_q <= `SCSS_GATE_PRI;
    end else if (ce) begin
      state_q <= state_d;
      cur_q <= cur_d;
      nxt_q <= nxt_d;
      gate_q <= gate_d;
    end
  end

  chk_gate_one_hot: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $onehot0(gate_q))
    else $error("more than one clock gate open");

  chk_break_make: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ($past(gate_q) != `SCSS_GATE_NONE && gate_q != `SCSS_GATE_NONE)
    |-> gate_q == $past(gate_q))
    else $error("gate moved without passing through closed");

  chk_pll_gate: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (state_q == st_run && cur_q == src_pll)
    |-> gate_q == `SCSS_GATE_PLL)
    else $error("pll selected but pll gate not alone open");

endmodule

// [tb/scss_osc_model.sv]
// behavioural oscillators, pll lock detector and clock gate cells
`timescale 1ns/100ps
module scss_osc_model #(
  parameter int LOCK_CYC = 5
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic slow,
  input wire logic sec_run,
  input wire logic pll_enable,
  input wire logic [2:0] clk_gate_en,
  output logic pll_lock,
  output logic [2:0] clk_gate_ack
);
  logic [3:0][2:0] dly_q;
  int cnt_q;
  logic [2:0] running;

  ////////////////////////////////////////////////////////////////////////////
  // a gate only reports passing clock while its oscillator really runs
  assign running = {sec_run, pll_lock, 1'b1};
  assign clk_gate_ack = (slow ? dly_q[3] : dly_q[0]) & running;
  assign pll_lock = (cnt_q == LOCK_CYC);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dly_q <= {4{3'h1}};
      cnt_q <= 0;
    end else begin
      dly_q <= {dly_q[2:0], clk_gate_en};
      if (!pll_enable) begin
        cnt_q <= 0;
      end else if (cnt_q != LOCK_CYC) begin
        cnt_q <= cnt_q + 1;
      end
    end
  end
endmodule

// [tb/testbench.sv]
// self-checking bench for the clock source switch
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
  $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module testbench;
  import scss_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic [3:0] osc_cfg = 4'h0;
  logic sw_cfg = 1'b1;
  logic sec_run = 1'b0;
  logic slow = 1'b0;
  logic ce = 1'b1;
  logic pll_lock;
  logic [2:0] clk_gate_ack;
  logic pll_enable;
  logic [2:0] clk_gate_en;
  logic [1:0] sys_clk_src;
  logic switch_busy;
  logic [31:0] q;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;

  always #50 hclk = ~hclk;

  scss_top u_scss_top (.hclk(hclk), .hresetn(hresetn), .ce(ce),
    .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .haddr(haddr), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .osc_type_config(osc_cfg),
    .switch_enable_config(sw_cfg), .secondary_osc_enable(sec_run),
    .pll_lock(pll_lock), .clk_gate_ack(clk_gate_ack),
    .pll_enable(pll_enable), .clk_gate_en(clk_gate_en),
    .sys_clk_src(sys_clk_src), .switch_busy(switch_busy));

  scss_osc_model u_scss_osc_model (.hclk(hclk), .hresetn(hresetn),
    .slow(slow), .sec_run(sec_run), .pll_enable(pll_enable),
    .clk_gate_en(clk_gate_en), .pll_lock(pll_lock),
    .clk_gate_ack(clk_gate_ack));

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // hang guard, plus no two gates ever open together
  always @(posedge hclk) begin
    cyc++;
    if (hresetn === 1'b1) `CHK($countones(clk_gate_en) <= 1, 1'b1)
    if (cyc == 4000) begin
      err_total++;
      stop_test();
    end
  end

  task automatic xfer(input logic w, input logic [31:0] a, d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr_rd(input logic [31:0] a, d, exp);
    xfer(1'b1, a, d);
    xfer(1'b0, a, 32'h0);
    `CHK(q, exp)
  endtask

  task automatic do_reset(input logic [3:0] m);
    osc_cfg <= m;
    hresetn <= 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    // first edge after release may update outputs; look after the second
    repeat (2) @(posedge hclk);
  endtask

  task automatic wait_idle(input logic [1:0] src, input logic [2:0] gate);
    repeat (2) @(posedge hclk);
    #1;
    while (switch_busy !== 1'b0) begin
      @(posedge hclk);
      #1;
    end
    `CHK(sys_clk_src, src)
    `CHK(clk_gate_en, gate)
    @(posedge hclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_forced();
    do_reset(4'h0);
    `CHK(clk_gate_en, 3'h1)
    `CHK(pll_enable, 1'b0)
    `CHK(hresp, 1'b0)
    `CHK(hready, 1'b1)
    wr_rd(32'h0, 32'hFFFFFFFF, 32'h0);
    `CHK(pll_enable, 1'b0)
    wr_rd(32'h4, 32'h1, 32'h0);
    `CHK(sys_clk_src, 2'h0)
  endtask

  task automatic t_secondary();
    sec_run <= 1'b1;
    sw_cfg <= 1'b1;
    wr_rd(32'h0, 32'h1, 32'h0);
    sw_cfg <= 1'b0;
    slow <= 1'b1;
    wr_rd(32'h0, 32'h1, 32'h1);
    `CHK(switch_busy, 1'b1)
    wait_idle(2'h2, 3'h4);
    slow <= 1'b0;
    wr_rd(32'h0, 32'h0, 32'h0);
    wait_idle(2'h0, 3'h1);
    wr_rd(32'h0, 32'h1, 32'h1);
    wait_idle(2'h2, 3'h4);
    do_reset(4'h0);
    `CHK(sys_clk_src, 2'h0)
    xfer(1'b0, 32'h0, 32'h0);
    `CHK(q, 32'h0)
  endtask

  task automatic t_soft_pll();
    sec_run <= 1'b0;
    do_reset(4'h6);
    wr_rd(32'h0, 32'h6, 32'h4);
    `CHK(pll_enable, 1'b1)
    repeat (10) @(posedge hclk);
    wr_rd(32'h0, 32'h6, 32'hE);
    wait_idle(2'h1, 3'h2);
    sec_run <= 1'b1;
    wr_rd(32'h0, 32'h7, 32'hF);
    wait_idle(2'h2, 3'h4);
    wr_rd(32'h0, 32'h2, 32'h0);
    wait_idle(2'h0, 3'h1);
    `CHK(pll_enable, 1'b0)
  endtask

  task automatic t_modes();
    logic cfg;
    for (int m = 4; m < 8; m++) begin
      cfg = (m < 6);
      do_reset(m[3:0]);
      `CHK(pll_enable, cfg)
      repeat (10) @(posedge hclk);
      wr_rd(32'h0, 32'h2, cfg ? 32'hC : 32'h0);
      wr_rd(32'h0, 32'h0, cfg ? 32'hC : 32'h0);
      `CHK(sys_clk_src, 2'h0)
    end
  endtask

  // clock enable low holds the forced pll enable off until it returns
  task automatic t_freeze();
    ce <= 1'b0;
    do_reset(4'h4);
    `CHK(pll_enable, 1'b0)
    ce <= 1'b1;
    repeat (2) @(posedge hclk);
    `CHK(pll_enable, 1'b1)
  endtask

  initial begin
    do_reset(4'h0);
    t_reset_forced();
    t_secondary();
    t_soft_pll();
    t_modes();
    t_freeze();
    stop_test();
  end
endmodule
